// ==== verilog/flex_pack_topology_decode.v ====
// Pack-topology configuration register and its decode
//
// Operation
// - Unsupported top cell: common switch only
// - Codes 0x8..0xE route supply to taps
// - Cell copies disagree: no masking, supply off
// - Top cell 0xF: no masking, supply off
// - Top block selects divider tap; 0xF sense
// - Top block 0x0..0x7 maps to 0xF
// - Unsupported top block: positive sense port
// - Flex disabled ignores top block
// - Option set: 30us wait before top sample
// - Delay needs flex, valid cell, alternate mux
// - Fields at bits 15, 14, 13, 11:8, 7:4, 3:0
// - Flex bits disagree: enabled, supply off
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "flex_pack_consts.vh"

module flex_pack_topology_decode #(
  parameter SCAN_DELAY_CYCLES = `FP_SCAN_DELAY_CYC
) (
  input wire clk, // 200 MHz system clock
  input wire arst_n, // Async reset, active low
  input wire wb_cyc_i, // Bus cycle
  input wire wb_stb_i, // Bus strobe
  input wire wb_we_i, // Write enable
  input wire [7:0] wb_adr_i, // Byte address
  input wire [3:0] wb_sel_i, // Byte selects
  input wire [31:0] wb_dat_i, // Write data
  output reg [31:0] wb_dat_o, // Read data
  output reg wb_ack_o, // Acknowledge
  output reg irq, // Level interrupt
  input wire alternate_mux_select, // Effective alternate mux select
  input wire scan_topcell_req, // Pulse: about to sample top cell
  output wire scan_sample_go, // Pulse: sample top cell now
  output wire scan_delay_busy, // Settling delay running
  output reg [6:0] supply_tap_en, // Taps 8..14 to supply pin
  output reg supply_common_en, // Common supply switch
  output reg [3:0] block_tap_sel, // Divider tap code
  output reg block_sense_pos_sel, // Divider on positive sense port
  output reg [13:0] balance_alert_mask // Masked balance alerts
);

  // Configuration register
  reg [15:0] pack_topology_config;

  // Interrupt state
  reg [`FP_IRQ_W-1:0] irq_status;
  reg [`FP_IRQ_W-1:0] irq_mask;

  // Registered decode results
  reg flex_eff;
  reg flex_ok;
  reg cell_ok;
  reg delay_en;

  // Previous agreement, for mismatch events
  reg cell_ok_prev;
  reg flex_ok_prev;

  // Bus request decode
  wire req;
  wire wr;
  wire hit_cfg;
  wire hit_stat;
  wire hit_ista;
  wire hit_imsk;

  // Field views
  wire flex_en_a;
  wire flex_en_b;
  wire flex_scan_delay_opt;
  wire [3:0] top_block_sel;
  wire [3:0] top_cell_sel_a;
  wire [3:0] top_cell_sel_b;

  // Resolved redundant fields
  wire flex_agree;
  wire [0:0] flex_val;
  wire cell_agree;
  wire [3:0] cell_val;

  // Timer results
  wire delay_done;
  wire timer_go;
  wire timer_busy;

  // Next values
  reg [15:0] next_cfg;
  reg [`FP_IRQ_W-1:0] next_irq_status;
  reg [`FP_IRQ_W-1:0] events;
  reg [6:0] next_taps;
  reg next_common;
  reg [3:0] next_block;
  reg next_block_pos;
  reg [13:0] next_mask;
  reg next_delay_en;
  reg next_cell_ok;
  reg tap_on;
  reg blk_ok;
  reg [31:0] rd_mux;
  integer i;

  // Field positions
  assign flex_en_b = pack_topology_config[`FP_BIT_FLEX_B];
  assign flex_en_a = pack_topology_config[`FP_BIT_FLEX_A];
  assign flex_scan_delay_opt = pack_topology_config[`FP_BIT_SCAN_OPT];
  assign top_block_sel = pack_topology_config[`FP_BLK_HI:`FP_BLK_LO];
  assign top_cell_sel_b = pack_topology_config[`FP_CELL_B_HI:`FP_CELL_B_LO];
  assign top_cell_sel_a = pack_topology_config[`FP_CELL_A_HI:`FP_CELL_A_LO];

  // Flex enable copies; a split vote falls back to enabled
  redundant_pair #(
    .WIDTH(1),
    .FALLBACK(1'b1)
  ) u_flex_pair (
    .copy_a(flex_en_a),
    .copy_b(flex_en_b),
    .agree(flex_agree),
    .value(flex_val)
  );

  // Top cell copies; a split vote falls back to 0xF
  redundant_pair #(
    .WIDTH(4),
    .FALLBACK(`FP_CODE_OFF)
  ) u_cell_pair (
    .copy_a(top_cell_sel_a),
    .copy_b(top_cell_sel_b),
    .agree(cell_agree),
    .value(cell_val)
  );

  // Bus decode: single-cycle answer, one request per ack
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes land at the edge that sees ack high, the same edge the master completes on
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign hit_cfg = (wb_adr_i == `FP_OFS_CFG);
  assign hit_stat = (wb_adr_i == `FP_OFS_STAT);
  assign hit_ista = (wb_adr_i == `FP_OFS_IRQ_STAT);
  assign hit_imsk = (wb_adr_i == `FP_OFS_IRQ_MASK);

  // Configuration write with byte lanes; reserved bit stays zero
  always @* begin
    next_cfg = pack_topology_config;
    if (wr && hit_cfg) begin
      if (wb_sel_i[0]) begin
        next_cfg[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        next_cfg[15:8] = wb_dat_i[15:8];
      end
      next_cfg = next_cfg & `FP_CFG_WMASK;
    end
  end

  // Decode of the stored fields; recomputed every cycle
  always @* begin
    next_cell_ok = cell_agree && (cell_val >= `FP_CODE_MIN) && (cell_val <= `FP_CODE_MAX);
    // Supply taps only in flex mode with both enable copies agreeing
    tap_on = flex_val[0] && flex_agree && next_cell_ok;
    next_taps = 7'h00;
    if (tap_on) begin
      next_taps = 7'h01 << cell_val[2:0];
    end
    // Off position: individual switches open, common closed
    next_common = ~tap_on;
    // Divider tap only for supported codes while flex is on
    blk_ok = flex_val[0] && (top_block_sel >= `FP_CODE_MIN) && (top_block_sel <= `FP_CODE_MAX);
    next_block = blk_ok ? top_block_sel : `FP_CODE_OFF;
    next_block_pos = ~blk_ok;
    // Mask balance alerts of the agreed top cell and the cells above it
    next_mask = 14'h0000;
    for (i = 0; i < 14; i = i + 1) begin
      if (cell_agree && (cell_val != `FP_CODE_OFF) && (cell_val <= i[3:0])) begin
        next_mask[i] = 1'b1;
      end
    end
    // Settling delay wanted when the option and conditions hold
    next_delay_en = flex_scan_delay_opt && flex_val[0] && next_cell_ok;
  end

  // Registered decode outputs, updated after every write
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      supply_tap_en <= 7'h00;
      supply_common_en <= 1'b1;
      block_tap_sel <= `FP_CODE_OFF;
      block_sense_pos_sel <= 1'b1;
      balance_alert_mask <= 14'h0000;
      flex_eff <= 1'b1;
      flex_ok <= 1'b1;
      cell_ok <= 1'b0;
      delay_en <= 1'b0;
    end else begin
      supply_tap_en <= next_taps;
      supply_common_en <= next_common;
      block_tap_sel <= next_block;
      block_sense_pos_sel <= next_block_pos;
      balance_alert_mask <= next_mask;
      flex_eff <= flex_val[0];
      flex_ok <= flex_agree;
      cell_ok <= next_cell_ok;
      delay_en <= next_delay_en;
    end
  end

  // Settling delay; alternate mux select is sampled at the request
  scan_delay_timer #(
    .CYCLES(SCAN_DELAY_CYCLES)
  ) u_timer (
    .clk(clk),
    .arst_n(arst_n),
    .start(scan_topcell_req),
    .insert(delay_en & alternate_mux_select),
    .go(timer_go),
    .done(delay_done),
    .busy(timer_busy)
  );

  assign scan_sample_go = timer_go;
  assign scan_delay_busy = timer_busy;

  // Interrupt events: a copy pair falling out of agreement, delay end
  always @* begin
    events = {`FP_IRQ_W{1'b0}};
    events[`FP_IRQ_CELL_MM] = cell_ok_prev & ~cell_agree;
    events[`FP_IRQ_FLEX_MM] = flex_ok_prev & ~flex_agree;
    events[`FP_IRQ_DELAY] = delay_done;
    next_irq_status = irq_status;
    if (wr && hit_ista && wb_sel_i[0]) begin
      next_irq_status = irq_status & ~wb_dat_i[`FP_IRQ_W-1:0];
    end
    // Set wins over a same-cycle clear so no event is lost
    next_irq_status = next_irq_status | events;
  end

  // Sticky status, mask and interrupt line
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= {`FP_IRQ_W{1'b0}};
      irq_mask <= {`FP_IRQ_W{1'b0}};
      cell_ok_prev <= 1'b1;
      flex_ok_prev <= 1'b1;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      if (wr && hit_imsk && wb_sel_i[0]) begin
        irq_mask <= wb_dat_i[`FP_IRQ_W-1:0];
      end
      cell_ok_prev <= cell_agree;
      flex_ok_prev <= flex_agree;
      irq <= |(next_irq_status & irq_mask);
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    rd_mux = 32'h00000000;
    if (hit_cfg) begin
      rd_mux[15:0] = pack_topology_config;
    end else if (hit_stat) begin
      rd_mux[`FP_ST_TAP_HI:0] = supply_tap_en;
      rd_mux[`FP_ST_COMMON] = supply_common_en;
      rd_mux[`FP_ST_BLK_HI:`FP_ST_BLK_LO] = block_tap_sel;
      rd_mux[`FP_ST_FLEX] = flex_eff;
      rd_mux[`FP_ST_CELL_OK] = cell_ok;
      rd_mux[`FP_ST_FLEX_OK] = flex_ok;
      rd_mux[`FP_ST_BUSY] = timer_busy;
      rd_mux[`FP_ST_MASK_HI:`FP_ST_MASK_LO] = balance_alert_mask;
    end else if (hit_ista) begin
      rd_mux[`FP_IRQ_W-1:0] = irq_status;
    end else if (hit_imsk) begin
      rd_mux[`FP_IRQ_W-1:0] = irq_mask;
    end
  end

  // Bus slave: ack one cycle after the request, dropped the next
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pack_topology_config <= `FP_CFG_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      pack_topology_config <= next_cfg;
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

endmodule // flex_pack_topology_decode

// ==== inc/flex_pack_consts.vh ====
// Constants for the pack-topology decode block
`ifndef FLEX_PACK_CONSTS_VH
`define FLEX_PACK_CONSTS_VH

// Register byte offsets on the bus
`define FP_OFS_CFG 8'h00
`define FP_OFS_STAT 8'h04
`define FP_OFS_IRQ_STAT 8'h08
`define FP_OFS_IRQ_MASK 8'h0c

// Configuration register fields
`define FP_BIT_FLEX_B 15
`define FP_BIT_FLEX_A 14
`define FP_BIT_SCAN_OPT 13
`define FP_BLK_HI 11
`define FP_BLK_LO 8
`define FP_CELL_B_HI 7
`define FP_CELL_B_LO 4
`define FP_CELL_A_HI 3
`define FP_CELL_A_LO 0

// Reset value and writable bits (bit 12 reserved)
`define FP_CFG_RESET 16'hefff
`define FP_CFG_WMASK 16'hefff

// Code values
`define FP_CODE_OFF 4'hf
`define FP_CODE_MIN 4'h8
`define FP_CODE_MAX 4'he

// Status register fields
`define FP_ST_TAP_HI 6
`define FP_ST_COMMON 7
`define FP_ST_BLK_HI 11
`define FP_ST_BLK_LO 8
`define FP_ST_FLEX 12
`define FP_ST_CELL_OK 13
`define FP_ST_FLEX_OK 14
`define FP_ST_BUSY 15
`define FP_ST_MASK_LO 16
`define FP_ST_MASK_HI 29

// Interrupt bits
`define FP_IRQ_CELL_MM 0
`define FP_IRQ_FLEX_MM 1
`define FP_IRQ_DELAY 2
`define FP_IRQ_W 3

// Scan settling delay
`define FP_CLK_PERIOD_NS 5
`define FP_SCAN_DELAY_NS 30000
`define FP_SCAN_DELAY_CYC ((`FP_SCAN_DELAY_NS + `FP_CLK_PERIOD_NS - 1) / `FP_CLK_PERIOD_NS)

`endif

// ==== verilog/redundant_pair.v ====
// Redundant field pair check with fallback value
`timescale 1ns/1ps
module redundant_pair #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] FALLBACK = {WIDTH{1'b1}}
) (
  input wire [WIDTH-1:0] copy_a, // First copy
  input wire [WIDTH-1:0] copy_b, // Second copy
  output wire agree, // Copies match
  output wire [WIDTH-1:0] value // Agreed value or fallback
);

  // A disagreement must never leave one copy in charge
  assign agree = (copy_a == copy_b);
  assign value = agree ? copy_a : FALLBACK;

endmodule // redundant_pair

// ==== verilog/scan_delay_timer.v ====
// Settling delay before the top-cell sample of a scan
`timescale 1ns/1ps
module scan_delay_timer #(
  parameter CYCLES = 6000
) (
  input wire clk, // System clock
  input wire arst_n, // Async reset, active low
  input wire start, // Sequencer wants to sample top cell
  input wire insert, // Delay applies to this scan
  output reg go, // Pulse: sample now
  output reg done, // Pulse: a delay completed
  output reg busy // Delay running
);

  // Counter holds up to 8191 cycles; the count is cut to that width on purpose
  localparam [31:0] LOAD_FULL = CYCLES - 1;
  localparam [12:0] LOAD = LOAD_FULL[12:0];

  reg [12:0] count;

  // Starts during a running delay are ignored
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 13'h0000;
      go <= 1'b0;
      done <= 1'b0;
      busy <= 1'b0;
    end else begin
      go <= 1'b0;
      done <= 1'b0;
      if (busy) begin
        if (count == 13'h0000) begin
          busy <= 1'b0;
          go <= 1'b1;
          done <= 1'b1;
        end else begin
          count <= count - 13'h0001;
        end
      end else if (start) begin
        if (insert) begin
          busy <= 1'b1;
          count <= LOAD;
        end else begin
          go <= 1'b1;
        end
      end
    end
  end

endmodule // scan_delay_timer

// ==== bench/flex_pack_chk.sv ====
// Port-level checker for the pack-topology decode block
`timescale 1ns/1ps
module flex_pack_chk #(
  parameter SCAN_DELAY_CYCLES = 8
) (
  input wire clk, // Clock
  input wire arst_n, // Reset, active low
  input wire wb_cyc_i, // Bus cycle
  input wire wb_stb_i, // Bus strobe
  input wire wb_ack_o, // Acknowledge
  input wire scan_topcell_req, // Top-cell request
  input wire alternate_mux_select, // Alternate mux
  input wire scan_sample_go, // Sample now
  input wire scan_delay_busy, // Delay running
  input wire [6:0] supply_tap_en, // Supply taps
  input wire supply_common_en, // Common switch
  input wire [3:0] block_tap_sel, // Divider tap
  input wire block_sense_pos_sel, // Sense port
  input wire [13:0] balance_alert_mask // Alert mask
);
  reg [15:0] busy_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Length of the running delay, compared when busy drops
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) busy_cnt <= 16'h0000;
    else busy_cnt <= scan_delay_busy ? busy_cnt + 16'h0001 : 16'h0000;
  end
  // Bus answer timing
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  // Decode consistency
  property p_common; supply_common_en == (supply_tap_en == 7'h00); endproperty
  a_common: assert property (p_common) else $error("common switch wrong");
  property p_onehot; $onehot0(supply_tap_en); endproperty
  a_onehot: assert property (p_onehot) else $error("several taps on");
  property p_blk_range; block_tap_sel[3]; endproperty
  a_blk_range: assert property (p_blk_range) else $error("low block code");
  property p_pos_port; block_sense_pos_sel == (block_tap_sel == 4'hf); endproperty
  a_pos_port: assert property (p_pos_port) else $error("sense port wrong");
  property p_mask_thermo; ((balance_alert_mask << 1) & ~balance_alert_mask) == 14'h0000; endproperty
  a_mask_thermo: assert property (p_mask_thermo) else $error("mask has gap");
  // Scan settling delay
  property p_no_delay;
    scan_topcell_req && !scan_delay_busy && !alternate_mux_select |=> scan_sample_go;
  endproperty
  a_no_delay: assert property (p_no_delay) else $error("plain scan delayed");
  property p_delay_len; $fell(scan_delay_busy) |-> scan_sample_go && busy_cnt == SCAN_DELAY_CYCLES; endproperty
  a_delay_len: assert property (p_delay_len) else $error("delay length wrong");
  property p_busy_quiet; scan_delay_busy |-> !scan_sample_go; endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("sample during delay");
  c_ack: cover property (wb_ack_o);
  c_delay: cover property ($fell(scan_delay_busy));
  c_tap: cover property (supply_tap_en != 7'h00);
  c_mask: cover property (balance_alert_mask != 14'h0000);
endmodule // flex_pack_chk

// ==== bench/flex_pack_topology_decode_test.sv ====
// Self-checking bench for the pack-topology decode block
`timescale 1ns/1ps
`include "flex_pack_consts.vh"
module flex_pack_topology_decode_test;
  localparam CYC = 8;
  localparam [127:0] CORNERS = {16'he888, 16'heeee, 16'he777, 16'he8e8,
    16'ha899, 16'h2a99, 16'hefff, 16'h6f00};
  reg clk = 1'b0;
  reg arst_n = 1'b0;
  reg cyc = 1'b0, stb = 1'b0, we = 1'b0, alt = 1'b0, req = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [31:0] wdat = 32'h0, rd, lfsr = 32'h3c8212b0;
  reg [15:0] cfg;
  wire [31:0] rdat;
  wire ack, irq, go, busy, common, pos;
  wire [6:0] taps;
  wire [3:0] blk;
  wire [13:0] mask;
  integer fail_count = 0, check_count = 0, i, n;
  always #2.5 clk = ~clk;
  flex_pack_topology_decode #(.SCAN_DELAY_CYCLES(CYC)) u_dut (.clk(clk), .arst_n(arst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq), .alternate_mux_select(alt),
    .scan_topcell_req(req), .scan_sample_go(go), .scan_delay_busy(busy), .supply_tap_en(taps),
    .supply_common_en(common), .block_tap_sel(blk), .block_sense_pos_sel(pos), .balance_alert_mask(mask));
  function [31:0] lfsr_step(input [31:0] s);
    lfsr_step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected decode, worked out from the field values
  function [6:0] e_taps(input [15:0] c);
    e_taps = (c[15] && c[14] && c[7:4] == c[3:0] && c[3:0] >= 4'h8 && c[3:0] <= 4'he) ?
      7'h01 << (c[3:0] - 4'h8) : 7'h00;
  endfunction
  function [3:0] e_blk(input [15:0] c);
    e_blk = ((c[15] | c[14]) && c[11:8] >= 4'h8 && c[11:8] != 4'hf) ? c[11:8] : 4'hf;
  endfunction
  function [13:0] e_mask(input [15:0] c);
    integer j;
    for (j = 0; j < 14; j = j + 1) e_mask[j] = c[7:4] == c[3:0] && c[3:0] != 4'hf && j >= c[3:0];
  endfunction
  // Status word: mask, busy, flex agree, cell ok, flex effective, block, common, taps
  function [31:0] e_stat(input [15:0] c);
    e_stat = {2'b00, e_mask(c), 1'b0, c[15] == c[14],
      c[7:4] == c[3:0] && c[3:0] >= 4'h8 && c[3:0] <= 4'he,
      c[15] | c[14], e_blk(c), e_taps(c) == 7'h00, e_taps(c)};
  endfunction
  task check(input [8*10:1] name, input [31:0] seen, input [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("MISMATCH %0s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One classic cycle; held until ack is sampled high
  task bus(input w, input [7:0] a, input [31:0] d);
    integer k;
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    k = 0;
    do begin @(posedge clk); k = k + 1; end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) fail_count = fail_count + 1;
    rd = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask
  task outs(input [15:0] c);
    check("taps", taps, e_taps(c));
    check("common", common, e_taps(c) == 7'h00);
    check("block", blk, e_blk(c));
    check("pos", pos, e_blk(c) == 4'hf);
    check("mask", mask, e_mask(c));
  endtask
  task decode(input [15:0] c);
    bus(1'b1, `FP_OFS_CFG, {16'h0000, c});
    bus(1'b0, `FP_OFS_CFG, 32'h0);
    check("readback", rd, c & 16'hefff);
    repeat (2) @(posedge clk);
    #1 outs(c);
    bus(1'b0, `FP_OFS_STAT, 32'h0);
    check("status", rd, e_stat(c));
  endtask
  // Count edges from the taken request to the sample pulse
  task scan(input a, input [31:0] exp_n);
    @(posedge clk);
    {alt, req} <= {a, 1'b1};
    @(posedge clk);
    req <= 1'b0;
    n = 1;
    #1;
    while (go !== 1'b1 && n < 50) begin @(posedge clk); #1 n = n + 1; end
    check("scan wait", n, exp_n);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count = fail_count + 1;
    finish_test;
  end
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    #1 outs(16'hefff);
    bus(1'b0, `FP_OFS_CFG, 32'h0);
    check("cfg reset", rd, 32'h0000efff);
    $display("test reset done");
    for (i = 0; i < 48; i = i + 1) begin
      lfsr = lfsr_step(lfsr);
      cfg = lfsr[15:0];
      if (lfsr[16]) cfg[7:4] = cfg[3:0];
      decode(i < 8 ? CORNERS[i*16 +: 16] : cfg);
    end
    bus(1'b1, 8'h10, 32'hffffffff);
    bus(1'b0, 8'h10, 32'h0);
    check("unmapped", rd, 32'h0);
    $display("test decode done");
    bus(1'b1, `FP_OFS_IRQ_STAT, 32'h7);
    decode(16'he999);
    scan(1'b1, CYC + 1);
    scan(1'b0, 1);
    bus(1'b0, `FP_OFS_IRQ_STAT, 32'h0);
    check("irq stat", rd, 32'h4);
    check("irq off", irq, 1'b0);
    bus(1'b1, `FP_OFS_IRQ_MASK, 32'h4);
    repeat (2) @(posedge clk);
    #1 check("irq on", irq, 1'b1);
    bus(1'b1, `FP_OFS_IRQ_STAT, 32'h4);
    repeat (2) @(posedge clk);
    #1 check("irq clear", irq, 1'b0);
    decode(16'hc999);
    scan(1'b1, 1);
    decode(16'h2999);
    scan(1'b1, 1);
    decode(16'he9a9);
    scan(1'b1, 1);
    bus(1'b0, `FP_OFS_IRQ_STAT, 32'h0);
    check("cell event", rd, 32'h1);
    $display("test scan done");
    finish_test;
  end
endmodule // flex_pack_topology_decode_test
bind flex_pack_topology_decode flex_pack_chk #(.SCAN_DELAY_CYCLES(SCAN_DELAY_CYCLES)) u_chk (
  .clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .scan_topcell_req(scan_topcell_req), .alternate_mux_select(alternate_mux_select),
  .scan_sample_go(scan_sample_go), .scan_delay_busy(scan_delay_busy), .supply_tap_en(supply_tap_en),
  .supply_common_en(supply_common_en), .block_tap_sel(block_tap_sel),
  .block_sense_pos_sel(block_sense_pos_sel), .balance_alert_mask(balance_alert_mask));
